// file: common/crm_defs.svh
// Purpose: Offsets, field positions and reset values of the control register map
// Assumes: Byte-wide registers behind an 8-bit address pointer
// Notes:   Included by bare name
`ifndef CRM_DEFS_SVH
`define CRM_DEFS_SVH

`define CRM_PTR_RESET        8'h01
`define CRM_PTR_ADV_BIT      7
`define CRM_OFS_MISC_ONE     7'h01
`define CRM_OFS_MISC_TWO     7'h02
`define CRM_OFS_DATA_FLOW    7'h03
`define CRM_OFS_CLK_SRC      7'h04
`define CRM_OFS_SER_IN       7'h05
`define CRM_OFS_SER_OUT      7'h06
`define CRM_OFS_IRQ1_STAT    7'h07
`define CRM_OFS_IRQ2_STAT    7'h08
`define CRM_OFS_IRQ1_MASK    7'h09
`define CRM_OFS_IRQ1_MODE_H  7'h0A
`define CRM_OFS_IRQ1_MODE_L  7'h0B
`define CRM_OFS_IRQ2_MASK    7'h0C
`define CRM_OFS_IRQ2_MODE_H  7'h0D
`define CRM_OFS_IRQ2_MODE_L  7'h0E
`define CRM_OFS_RX_CS        7'h0F
`define CRM_OFS_RX_ERR       7'h10
`define CRM_OFS_RX_ERR_MASK  7'h11
`define CRM_OFS_CS_BUF_CTL   7'h12
`define CRM_OFS_U_BUF_CTL    7'h13
`define CRM_OFS_SUBCODE_LO   7'h14
`define CRM_OFS_SUBCODE_HI   7'h1D
`define CRM_OFS_RATE_RATIO   7'h1E
`define CRM_OFS_BUF_LO       7'h20
`define CRM_OFS_BUF_HI       7'h37
`define CRM_OFS_IDENT        7'h7F

// Bits that read back in the map; bits clear in a mask read as zero
`define CRM_MASK_CLK_SRC     8'h7F
`define CRM_MASK_IRQ2        8'h3F
`define CRM_MASK_RX_ERR      8'h7F
`define CRM_MASK_CS_BUF      8'h3F
`define CRM_MASK_U_BUF       8'h1F

// Control register reset values
`define CRM_RST_ZERO         8'h00

// Mode codes, high bit then low bit
`define CRM_MODE_RISE        2'h0
`define CRM_MODE_FALL        2'h1
`define CRM_MODE_LEVEL       2'h2

`endif

// file: common/crm_pkg.sv
// Purpose: Types of the control register map
// Assumes: crm_defs.svh for numbers
// Notes:   Types only
package crm_pkg;

  typedef logic [7:0] crm_byte_t;

  typedef struct packed {
    logic [7:0]  ptr;
    logic [7:0]  misc_one;
    logic [7:0]  misc_two;
    logic [7:0]  data_flow;
    logic [7:0]  clk_src;
    logic [7:0]  ser_in;
    logic [7:0]  ser_out;
    logic [7:0]  irq1_stat;
    logic [7:0]  irq2_stat;
    logic [7:0]  irq1_mask;
    logic [7:0]  irq1_mode_h;
    logic [7:0]  irq1_mode_l;
    logic [7:0]  irq2_mask;
    logic [7:0]  irq2_mode_h;
    logic [7:0]  irq2_mode_l;
    logic [7:0]  rx_err;
    logic [7:0]  rx_err_mask;
    logic [7:0]  cs_buf_ctl;
    logic [7:0]  u_buf_ctl;
    logic [7:0]  src1_q;
    logic [7:0]  src2_q;
    logic [7:0]  rd_data;
    logic        irq;
  } crm_state_s;

endpackage : crm_pkg

// file: rtl/crm_regs.sv
// Purpose: Control register bank and address pointer of the audio converter
// Assumes: Serial port front end delivers decoded byte strobes on clk
// Notes:   Event inputs come from core logic on clk, not synchronised
//
// Behaviour
// R1 - Pointer top bit set enables address advance; cleared disables it.
// R2 - Pointer low seven bits select the register for next access.
// R3 - Addresses 20-29 and 31 reserved; 30 rate ratio; 32-55 buffer. Reads at 20-29 return subcode storage.
// R4 - Host never writes reserved addresses during normal operation.
// R5 - Some reserved locations control test modes, altering normal behaviour.
// R6 - Each interrupt group has status, mask, and high/low mode registers.
// R7 - With advance on, pointer steps after each byte; otherwise fixed.
// R8 - Two mode bits select rising edge, falling edge or level trigger.
// R9 - Reserved addresses and zero-printed bits read back as zero; reads at reserved 20-29 return subcode storage instead.
`timescale 1ns/1ps
`include "crm_defs.svh"

module crm_regs #(
  parameter int BUF_DEPTH = 24,
  parameter int SUB_DEPTH = 10,
  parameter logic [7:0] IDENT_VALUE = 8'h5A  // Arbitrary identity value
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        ptr_wr,
  input  wire logic [7:0]  ptr_wdata,
  input  wire logic        data_wr,
  input  wire logic [7:0]  data_wdata,
  input  wire logic        data_rd,
  input  wire logic [7:0]  irq1_src,
  input  wire logic [7:0]  irq2_src,
  input  wire logic [7:0]  rx_err_src,
  input  wire logic [7:0]  rx_cs_in,
  input  wire logic [7:0]  rate_ratio_in,
  input  wire logic        sub_wr,
  input  wire logic [3:0]  sub_idx,
  input  wire logic [7:0]  sub_wdata,
  output logic      [7:0]  address_pointer,
  output logic      [7:0]  rd_data,
  output logic      [7:0]  misc_control_one,
  output logic      [7:0]  misc_control_two,
  output logic      [7:0]  data_flow_control,
  output logic      [7:0]  clock_source_control,
  output logic      [7:0]  serial_input_format,
  output logic      [7:0]  serial_output_format,
  output logic      [7:0]  status_buffer_control,
  output logic      [7:0]  user_buffer_control,
  output logic             test_mode_write,
  output logic             irq
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  crm_pkg::crm_state_s st;
  crm_pkg::crm_state_s next_st;
  logic [7:0] buf_mem [BUF_DEPTH];
  logic [7:0] sub_mem [SUB_DEPTH];
  logic       test_wr_q;

  logic [6:0] cur_addr;
  logic [6:0] rd_addr;
  logic       adv;
  logic       is_reserved;
  logic       buf_hit;
  logic [4:0] buf_idx;
  logic [4:0] rd_buf_idx;
  logic [3:0] rd_sub_idx;
  logic [7:0] rd_mux;
  logic [7:0] irq1_hit;
  logic [7:0] irq2_hit;
  logic [7:0] err_hit;

  // ----------------------------------------
  // Event detection per mode pair
  // ----------------------------------------
  function automatic logic [7:0] crm_detect(input logic [7:0] cur, input logic [7:0] prev,
                                            input logic [7:0] mh, input logic [7:0] ml);
    logic [7:0] res;
    res = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      case ({mh[i], ml[i]})  // [R8]
        `CRM_MODE_RISE:  res[i] = cur[i] & ~prev[i];
        `CRM_MODE_FALL:  res[i] = ~cur[i] & prev[i];
        `CRM_MODE_LEVEL: res[i] = cur[i];
        default:         res[i] = 1'b0;
      endcase
    end
    return res;
  endfunction

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  always_comb
  begin
    cur_addr    = st.ptr[6:0];                                   // [R2]
    adv         = st.ptr[`CRM_PTR_ADV_BIT];                      // [R1]
    buf_hit     = (cur_addr >= `CRM_OFS_BUF_LO) && (cur_addr <= `CRM_OFS_BUF_HI);  // [R3]
    buf_idx     = 5'(cur_addr - `CRM_OFS_BUF_LO);
    is_reserved = 1'b0;
    case (cur_addr)
      7'h00,
      `CRM_OFS_IRQ1_STAT, `CRM_OFS_IRQ2_STAT, `CRM_OFS_RX_CS, `CRM_OFS_RX_ERR,
      `CRM_OFS_RATE_RATIO, `CRM_OFS_IDENT:
        is_reserved = 1'b0;
      `CRM_OFS_MISC_ONE, `CRM_OFS_MISC_TWO, `CRM_OFS_DATA_FLOW, `CRM_OFS_CLK_SRC,
      `CRM_OFS_SER_IN, `CRM_OFS_SER_OUT, `CRM_OFS_IRQ1_MASK, `CRM_OFS_IRQ1_MODE_H,
      `CRM_OFS_IRQ1_MODE_L, `CRM_OFS_IRQ2_MASK, `CRM_OFS_IRQ2_MODE_H, `CRM_OFS_IRQ2_MODE_L,
      `CRM_OFS_RX_ERR_MASK, `CRM_OFS_CS_BUF_CTL, `CRM_OFS_U_BUF_CTL:
        is_reserved = 1'b0;
      default:
        is_reserved = !buf_hit;                                  // [R3]
    endcase
  end

  // ----------------------------------------
  // Read multiplexer
  // ----------------------------------------
  // Reads use the pointer as it will stand after any advance, so data is ready for the next byte
  always_comb
  begin
    rd_addr    = next_st.ptr[6:0];
    rd_buf_idx = 5'(rd_addr - `CRM_OFS_BUF_LO);
    rd_sub_idx = 4'(rd_addr - `CRM_OFS_SUBCODE_LO);
    case (rd_addr)
      `CRM_OFS_MISC_ONE:    rd_mux = next_st.misc_one;
      `CRM_OFS_MISC_TWO:    rd_mux = next_st.misc_two;
      `CRM_OFS_DATA_FLOW:   rd_mux = next_st.data_flow;
      `CRM_OFS_CLK_SRC:     rd_mux = next_st.clk_src & `CRM_MASK_CLK_SRC;    // [R9]
      `CRM_OFS_SER_IN:      rd_mux = next_st.ser_in;
      `CRM_OFS_SER_OUT:     rd_mux = next_st.ser_out;
      `CRM_OFS_IRQ1_STAT:   rd_mux = st.irq1_stat;
      `CRM_OFS_IRQ2_STAT:   rd_mux = st.irq2_stat & `CRM_MASK_IRQ2;          // [R9]
      `CRM_OFS_IRQ1_MASK:   rd_mux = next_st.irq1_mask;
      `CRM_OFS_IRQ1_MODE_H: rd_mux = next_st.irq1_mode_h;
      `CRM_OFS_IRQ1_MODE_L: rd_mux = next_st.irq1_mode_l;
      `CRM_OFS_IRQ2_MASK:   rd_mux = next_st.irq2_mask & `CRM_MASK_IRQ2;
      `CRM_OFS_IRQ2_MODE_H: rd_mux = next_st.irq2_mode_h & `CRM_MASK_IRQ2;
      `CRM_OFS_IRQ2_MODE_L: rd_mux = next_st.irq2_mode_l & `CRM_MASK_IRQ2;
      `CRM_OFS_RX_CS:       rd_mux = rx_cs_in;
      `CRM_OFS_RX_ERR:      rd_mux = st.rx_err & `CRM_MASK_RX_ERR;
      `CRM_OFS_RX_ERR_MASK: rd_mux = next_st.rx_err_mask & `CRM_MASK_RX_ERR;
      `CRM_OFS_CS_BUF_CTL:  rd_mux = next_st.cs_buf_ctl & `CRM_MASK_CS_BUF;
      `CRM_OFS_U_BUF_CTL:   rd_mux = next_st.u_buf_ctl & `CRM_MASK_U_BUF;
      `CRM_OFS_RATE_RATIO:  rd_mux = rate_ratio_in;                          // [R3]
      `CRM_OFS_IDENT:       rd_mux = IDENT_VALUE;
      default:
      begin
        if ((rd_addr >= `CRM_OFS_SUBCODE_LO) && (rd_addr <= `CRM_OFS_SUBCODE_HI))
          rd_mux = sub_mem[rd_sub_idx];
        else if ((rd_addr >= `CRM_OFS_BUF_LO) && (rd_addr <= `CRM_OFS_BUF_HI))
          rd_mux = buf_mem[rd_buf_idx];                                      // [R3]
        else
          rd_mux = 8'h00;                                                    // [R9]
      end
    endcase
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    next_st = st;
    irq1_hit = crm_detect(irq1_src, st.src1_q, st.irq1_mode_h, st.irq1_mode_l);
    irq2_hit = crm_detect(irq2_src & `CRM_MASK_IRQ2, st.src2_q, st.irq2_mode_h, st.irq2_mode_l);
    err_hit  = rx_err_src & `CRM_MASK_RX_ERR;
    next_st.src1_q = irq1_src;
    next_st.src2_q = irq2_src & `CRM_MASK_IRQ2;

    if (ptr_wr)
      next_st.ptr = ptr_wdata;                                   // [R1] [R2]
    else if (data_wr && !is_reserved)
    begin
      case (cur_addr)
        `CRM_OFS_MISC_ONE:    next_st.misc_one    = data_wdata;
        `CRM_OFS_MISC_TWO:    next_st.misc_two    = data_wdata;
        `CRM_OFS_DATA_FLOW:   next_st.data_flow   = data_wdata;
        `CRM_OFS_CLK_SRC:     next_st.clk_src     = data_wdata & `CRM_MASK_CLK_SRC;
        `CRM_OFS_SER_IN:      next_st.ser_in      = data_wdata;
        `CRM_OFS_SER_OUT:     next_st.ser_out     = data_wdata;
        `CRM_OFS_IRQ1_MASK:   next_st.irq1_mask   = data_wdata;  // [R6]
        `CRM_OFS_IRQ1_MODE_H: next_st.irq1_mode_h = data_wdata;  // [R6]
        `CRM_OFS_IRQ1_MODE_L: next_st.irq1_mode_l = data_wdata;  // [R6]
        `CRM_OFS_IRQ2_MASK:   next_st.irq2_mask   = data_wdata & `CRM_MASK_IRQ2;
        `CRM_OFS_IRQ2_MODE_H: next_st.irq2_mode_h = data_wdata & `CRM_MASK_IRQ2;
        `CRM_OFS_IRQ2_MODE_L: next_st.irq2_mode_l = data_wdata & `CRM_MASK_IRQ2;
        `CRM_OFS_RX_ERR_MASK: next_st.rx_err_mask = data_wdata & `CRM_MASK_RX_ERR;
        `CRM_OFS_CS_BUF_CTL:  next_st.cs_buf_ctl  = data_wdata & `CRM_MASK_CS_BUF;
        `CRM_OFS_U_BUF_CTL:   next_st.u_buf_ctl   = data_wdata & `CRM_MASK_U_BUF;
        default:              next_st.ptr         = st.ptr;
      endcase
    end

    // Pointer wraps within seven bits; advance bit is kept
    if (!ptr_wr && (data_wr || data_rd) && adv)
      next_st.ptr = {st.ptr[7], 7'(st.ptr[6:0] + 7'h01)};       // [R7]

    // Status reads clear; a new event in the same cycle wins
    if (data_rd && cur_addr == `CRM_OFS_IRQ1_STAT)
      next_st.irq1_stat = 8'h00;
    if (data_rd && cur_addr == `CRM_OFS_IRQ2_STAT)
      next_st.irq2_stat = 8'h00;
    if (data_rd && cur_addr == `CRM_OFS_RX_ERR)
      next_st.rx_err = 8'h00;
    next_st.irq1_stat = next_st.irq1_stat | irq1_hit;            // [R6] [R8]
    next_st.irq2_stat = next_st.irq2_stat | irq2_hit;
    next_st.rx_err    = next_st.rx_err | err_hit;

    next_st.rd_data = rd_mux;
    next_st.irq = |(next_st.irq1_stat & next_st.irq1_mask) |
                  |(next_st.irq2_stat & next_st.irq2_mask);
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st       <= '0;
      st.ptr   <= `CRM_PTR_RESET;
      test_wr_q <= 1'b0;
    end
    else
    begin
      st        <= next_st;
      test_wr_q <= data_wr && !ptr_wr && is_reserved;            // [R4] [R5]
    end
  end

  // Buffer and subcode storage carry no reset; contents are undefined at power-up
  always_ff @(posedge clk)
  begin
    if (data_wr && !ptr_wr && buf_hit)
      buf_mem[buf_idx] <= data_wdata;                            // [R3]
    if (sub_wr && (int'(sub_idx) < SUB_DEPTH))
      sub_mem[sub_idx] <= sub_wdata;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign address_pointer       = st.ptr;
  assign rd_data               = st.rd_data;
  assign misc_control_one      = st.misc_one;
  assign misc_control_two      = st.misc_two;
  assign data_flow_control     = st.data_flow;
  assign clock_source_control  = st.clk_src;
  assign serial_input_format   = st.ser_in;
  assign serial_output_format  = st.ser_out;
  assign status_buffer_control = st.cs_buf_ctl;
  assign user_buffer_control   = st.u_buf_ctl;
  assign test_mode_write       = test_wr_q;
  assign irq                   = st.irq;

endmodule // crm_regs

// file: verification/crm_host.sv
// Purpose: Host side model driving pointer, write and read strobes
// Assumes: Strobes change on the falling edge, one cycle wide
// Notes:   Write data is inverted once released so stale bytes never pass
`timescale 1ns/1ps
module crm_host (
  input  wire logic       clk,
  input  wire logic [7:0] rd_data,
  output logic            ptr_wr,
  output logic      [7:0] ptr_wdata,
  output logic            data_wr,
  output logic      [7:0] data_wdata,
  output logic            data_rd
);
  initial
  begin
    ptr_wr     = 1'b0;
    ptr_wdata  = 8'h00;
    data_wr    = 1'b0;
    data_wdata = 8'h00;
    data_rd    = 1'b0;
  end
  task set_ptr(input logic [7:0] p);
    @(negedge clk);
    ptr_wdata = p;
    ptr_wr    = 1'b1;
    @(negedge clk);
    ptr_wr    = 1'b0;
  endtask
  // Reserved places are written only where a scenario asks for it
  task put(input logic [7:0] d);
    @(negedge clk);
    data_wdata = d;
    data_wr    = 1'b1;
    @(negedge clk);
    data_wr    = 1'b0;
    data_wdata = ~d;
  endtask
  task get(output logic [7:0] d);
    @(negedge clk);
    d       = rd_data;
    data_rd = 1'b1;
    @(negedge clk);
    data_rd = 1'b0;
  endtask
endmodule // crm_host

// file: verification/crm_regs_properties.sv
// Purpose: Port-level checks of the register bank
// Assumes: Single clock, asynchronous active-low reset
// Notes:   Attached by bind below
`timescale 1ns/1ps
`include "crm_defs.svh"
module crm_regs_properties (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       ptr_wr,
  input wire logic [7:0] ptr_wdata,
  input wire logic       data_wr,
  input wire logic [7:0] data_wdata,
  input wire logic       data_rd,
  input wire logic [7:0] address_pointer,
  input wire logic [7:0] rd_data,
  input wire logic [7:0] misc_control_one,
  input wire logic       test_mode_write
);
  logic rsv;
  assign rsv = address_pointer[6:0] == 7'h00 || address_pointer[6:0] == 7'h1F ||
               (address_pointer[6:0] >= 7'h38 && address_pointer[6:0] <= 7'h7E);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  ptr_load_a:
    assert property (ptr_wr |=> address_pointer == $past(ptr_wdata)) else $error("pointer load wrong");
  advance_on_a:
    assert property (!ptr_wr && (data_wr || data_rd) && address_pointer[7]
      |=> address_pointer == {1'b1, $past(address_pointer[6:0]) + 7'h01}) else $error("pointer did not step");
  advance_off_a:
    assert property (!ptr_wr && !address_pointer[7] |=> $stable(address_pointer)) else $error("pointer moved");
  idle_hold_a:
    assert property (!(ptr_wr || data_wr || data_rd) |=> $stable(address_pointer)) else $error("idle pointer moved");
  reserved_write_a:
    assert property (data_wr && !ptr_wr && rsv |-> ##[1:2] test_mode_write) else $error("no test mode pulse");
  pulse_cause_a:
    assert property (test_mode_write |-> $past(data_wr) || $past(data_wr, 2)) else $error("stray test mode pulse");
  reserved_read_a:
    assert property (rsv |-> rd_data == 8'h00) else $error("reserved read not zero");
  clock_bit_a:
    assert property (address_pointer[6:0] == `CRM_OFS_CLK_SRC |-> !rd_data[7]) else $error("zero bit read one");
  ctl_hold_a:
    assert property (!data_wr |=> $stable(misc_control_one)) else $error("control changed without write");
  write_land_a:
    assert property (data_wr && !ptr_wr && address_pointer[6:0] == `CRM_OFS_MISC_ONE
      |=> misc_control_one == $past(data_wdata)) else $error("control write lost");
  cover property (data_wr && address_pointer[7]);
  cover property (data_wr && rsv);
  cover property (data_rd && !address_pointer[7]);
endmodule // crm_regs_properties
bind crm_regs crm_regs_properties i_props (.clk(clk), .resetn(resetn), .ptr_wr(ptr_wr), .ptr_wdata(ptr_wdata),
  .data_wr(data_wr), .data_wdata(data_wdata), .data_rd(data_rd), .address_pointer(address_pointer),
  .rd_data(rd_data), .misc_control_one(misc_control_one), .test_mode_write(test_mode_write));

// file: verification/tb_crm_regs.sv
// Purpose: Directed tests of the register bank through host strobes
// Assumes: Inputs change on the falling edge
// Notes:   Sources start idle and are raised only where a scenario asks for it
`timescale 1ns/1ps
`include "crm_defs.svh"
module tb_crm_regs;
  localparam logic [7:0] IDENT = 8'h5A; // Arbitrary identity value
  logic       clk = 1'b0;
  logic       resetn = 1'b0;
  logic [7:0] irq1_src, irq2_src, rx_err_src, rx_cs_in, rate_in, sub_wdata;
  logic       sub_wr;
  logic [3:0] sub_idx;
  logic       pend;
  logic [7:0] v;
  logic [1:0] tm;
  wire        ptr_wr, data_wr, data_rd, tmw, irq;
  wire  [7:0] ptr_wdata, data_wdata, address_pointer, rd_data, mc1, mc2, dfc, csc, sif, sof, sbc, ubc;
  wire [47:0] ctl = {sof, sif, csc, dfc, mc2, mc1};
  int         fail_count = 0;
  int         cmp_count = 0;
  always #10 clk = ~clk;
  crm_host host (.clk(clk), .rd_data(rd_data), .ptr_wr(ptr_wr), .ptr_wdata(ptr_wdata), .data_wr(data_wr),
    .data_wdata(data_wdata), .data_rd(data_rd));
  crm_regs #(.IDENT_VALUE(IDENT)) i_crm_regs (.clk(clk), .resetn(resetn), .ptr_wr(ptr_wr),
    .ptr_wdata(ptr_wdata), .data_wr(data_wr), .data_wdata(data_wdata), .data_rd(data_rd), .irq1_src(irq1_src),
    .irq2_src(irq2_src), .rx_err_src(rx_err_src), .rx_cs_in(rx_cs_in), .rate_ratio_in(rate_in), .sub_wr(sub_wr),
    .sub_idx(sub_idx), .sub_wdata(sub_wdata), .address_pointer(address_pointer), .rd_data(rd_data),
    .misc_control_one(mc1), .misc_control_two(mc2), .data_flow_control(dfc), .clock_source_control(csc),
    .serial_input_format(sif), .serial_output_format(sof), .status_buffer_control(sbc),
    .user_buffer_control(ubc), .test_mode_write(tmw), .irq(irq));
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    host.set_ptr(a);
    host.get(v);
    chk("rd_data", e, v);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    host.set_ptr(a);
    host.put(d);
  endtask
  // Expected bits: status after rise, after a read while high, after fall
  task icase(input logic [1:0] m, input logic [2:0] e);
    wr(`CRM_OFS_IRQ1_MODE_H, {7'h00, m[1]});
    wr(`CRM_OFS_IRQ1_MODE_L, {7'h00, m[0]});
    // Status left by the previous case stays pending until this read
    rd(`CRM_OFS_IRQ1_STAT, {7'h00, pend});
    irq1_src = 8'h01;
    repeat (3) @(negedge clk);
    host.set_ptr(`CRM_OFS_IRQ1_STAT);
    chk("status", {7'h00, e[2]}, rd_data);
    chk("irq", {7'h00, e[2]}, {7'h00, irq});
    host.get(v);
    repeat (3) @(negedge clk);
    host.set_ptr(`CRM_OFS_IRQ1_STAT);
    chk("status", {7'h00, e[1]}, rd_data);
    irq1_src = 8'h00;
    repeat (3) @(negedge clk);
    host.set_ptr(`CRM_OFS_IRQ1_STAT);
    chk("status", {7'h00, e[0]}, rd_data);
    pend = e[0];
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    irq1_src   = 8'h00;
    irq2_src   = 8'h00;
    rx_err_src = 8'h00;
    rx_cs_in   = 8'h00;
    rate_in    = 8'h00;
    sub_wdata  = 8'h00;
    sub_wr     = 1'b0;
    sub_idx    = 4'h0;
    pend       = 1'b0;
    repeat (20) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    chk("pointer", `CRM_PTR_RESET, address_pointer);
    chk("misc_one", `CRM_RST_ZERO, mc1);
    host.set_ptr(8'h81);
    for (int i = 1; i < 7; i++) host.put(8'(8'h11 * i));
    chk("pointer", 8'h87, address_pointer);
    for (int i = 1; i < 7; i++) chk("control", 8'(8'h11 * i), ctl[8*(i-1)+:8]);
    host.set_ptr(8'h81);
    for (int i = 1; i < 7; i++)
    begin
      host.get(v);
      chk("readback", 8'(8'h11 * i), v);
    end
    $display("test advance done");
    wr(8'h05, 8'hA5);
    host.put(8'h5A);
    chk("pointer", 8'h05, address_pointer);
    chk("serial_in", 8'h5A, sif);
    host.set_ptr(8'h1F);
    host.put(8'hFF);
    tm[0] = tmw;
    @(negedge clk);
    tm[1] = tmw;
    chk("test_mode", 8'h01, {7'h00, |tm});
    rd(8'h1F, 8'h00);
    rd(8'h40, 8'h00);
    rd(8'h00, 8'h00);
    wr(`CRM_OFS_CLK_SRC, 8'hFF);
    rd(`CRM_OFS_CLK_SRC, `CRM_MASK_CLK_SRC);
    wr(`CRM_OFS_IRQ2_MASK, 8'hFF);
    rd(`CRM_OFS_IRQ2_MASK, `CRM_MASK_IRQ2);
    wr(`CRM_OFS_CS_BUF_CTL, 8'hFF);
    rd(`CRM_OFS_CS_BUF_CTL, `CRM_MASK_CS_BUF);
    chk("cs_buf_ctl", `CRM_MASK_CS_BUF, sbc);
    wr(`CRM_OFS_U_BUF_CTL, 8'hFF);
    rd(`CRM_OFS_U_BUF_CTL, `CRM_MASK_U_BUF);
    chk("u_buf_ctl", `CRM_MASK_U_BUF, ubc);
    $display("test reserved done");
    rate_in = 8'hC3;
    rx_cs_in = 8'h3C;
    sub_wr = 1'b1;
    sub_idx = 4'h9;
    sub_wdata = 8'h96;
    @(negedge clk);
    sub_wr = 1'b0;
    wr(`CRM_OFS_RATE_RATIO, 8'h00);
    rd(`CRM_OFS_RATE_RATIO, 8'hC3);
    rd(`CRM_OFS_RX_CS, 8'h3C);
    rd(`CRM_OFS_SUBCODE_HI, 8'h96);
    wr(`CRM_OFS_BUF_LO, 8'hA1);
    wr(`CRM_OFS_BUF_HI, 8'hB2);
    rd(`CRM_OFS_BUF_LO, 8'hA1);
    rd(`CRM_OFS_BUF_HI, 8'hB2);
    rd(`CRM_OFS_IDENT, IDENT);
    host.set_ptr(8'hFF);
    host.get(v);
    chk("ident", IDENT, v);
    chk("pointer", 8'h80, address_pointer);
    $display("test map done");
    wr(`CRM_OFS_IRQ1_MASK, 8'h01);
    icase(`CRM_MODE_RISE, 3'b100);
    icase(`CRM_MODE_FALL, 3'b001);
    icase(`CRM_MODE_LEVEL, 3'b111);
    icase(2'h3, 3'b000);
    // Group two: top two source bits must never reach status
    irq2_src = 8'hC1;
    repeat (3) @(negedge clk);
    irq2_src = 8'h00;
    chk("irq", 8'h01, {7'h00, irq});
    rd(`CRM_OFS_IRQ2_STAT, 8'h01);
    chk("irq", 8'h00, {7'h00, irq});
    rx_err_src = 8'hFF;
    repeat (3) @(negedge clk);
    rx_err_src = 8'h00;
    rd(`CRM_OFS_RX_ERR, `CRM_MASK_RX_ERR);
    rd(`CRM_OFS_RX_ERR, 8'h00);
    $display("test events done");
    give_verdict;
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    fail_count++;
    give_verdict;
  end
endmodule // tb_crm_regs
